// >>> src/fit_core.sv
// flag interrupt timer: background timer/counter plus polled flags interrupt
// How it works
// - masked flags compared with pattern
// - bit 7 carries timer overflow
// - bit 6 is slave write done
// - bit 5 is serial receive done
// - bit 4 comparator, bits 0-3 pin interrupts
// - one pair; off disarms, arm replaces
// - AND default, OR and NOT variants
// - NOT fires on mismatch, OR on any
// - evaluate at instruction, note, pause points
// - true condition calls handler, then resumes
// - taking interrupt disarms; rearm waits return
// - count mode counts input 0 rising edges
// - edge counter wrap increments timer word
// - minor tick every 256 core clocks
// - minor counter wrap gives major tick
// - reload hidden counter with preload on wrap
// - timer word wrap sets overflow flag
// - configure clears flag; software may clear
// - timer word always readable
// - configure selects mode, preload, starts; off stops
// - timer paused during debug dump
// - timer unavailable while servo active
`timescale 1ns/100ps
`include "fit_params.svh"
module fit_core (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // timer control from the program
  input wire logic timer_cfg,
  input wire fit_pkg::fit_cfg_t timer_cfg_val,
  input wire logic timer_off,
  input wire logic toflag_clr,
  input wire logic debug_dump_busy,
  input wire logic servo_active,
  // external count input
  input wire logic count_in0,
  // flag sources
  input wire logic slave_write_done_flag,
  input wire logic ser_rx_done_flag,
  input wire logic comp_out_flag,
  input wire logic ext_pin0_irq_flag,
  input wire logic ext_pin1_irq_flag,
  input wire logic ext_pin2_irq_flag,
  // matcher control from the program
  input wire logic int_arm,
  input wire fit_pkg::fit_arm_t int_arm_val,
  input wire logic int_off,
  input wire logic poll_point,
  input wire logic handler_return,
  // outputs
  output logic [15:0] timer_word,
  output logic [7:0] flags_byte,
  output logic timer_running,
  output logic timer_blocked,
  output logic int_armed,
  output logic int_call,
  output logic in_handler
);
  fit_pkg::fit_state_t st_r;
  fit_pkg::fit_state_t st_nxt;
  fit_pkg::fit_arm_t arm_r;
  fit_pkg::fit_arm_t arm_nxt;
  fit_pkg::fit_arm_t pend_r;
  fit_pkg::fit_arm_t pend_nxt;
  logic pend_valid_r;
  logic pend_valid_nxt;
  logic run_r;
  logic count_mode_r;
  logic [15:0] preload_r;
  logic [7:0] div_r;
  logic in0_d_r;
  logic [15:0] timer_r;
  logic [15:0] timer_nxt;
  logic toflag_r;
  logic toflag_nxt;
  logic hit;
  logic hidden_wrap;

  // servo owns the timer, debug dump suspends it
  wire blocked = servo_active;
  wire active = run_r && !blocked && !debug_dump_busy;
  wire minor_tick = active && !count_mode_r && (div_r == `FIT_MINOR_LAST);
  wire edge_tick = active && count_mode_r && count_in0 && !in0_d_r;
  wire hidden_step = count_mode_r ? edge_tick : minor_tick;
  wire major_tick = hidden_wrap;
  wire word_wrap = major_tick && (timer_r == `FIT_WORD_MAX);

  // wrap reloads the stored preload, not whatever sits on the config port later
  wire [15:0] preload_sel = timer_cfg ? timer_cfg_val.preload : preload_r;

  fit_tick_counter u_hidden (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .load(timer_cfg),
    .preload(preload_sel),
    .step(hidden_step && !timer_cfg),
    .wrap(hidden_wrap)
  );

  // live flags byte; bit 7 is the sticky overflow flag
  wire any_pin = ext_pin0_irq_flag || ext_pin1_irq_flag || ext_pin2_irq_flag;
  wire [7:0] flags_live = {toflag_r, slave_write_done_flag, ser_rx_done_flag, comp_out_flag,
                           any_pin, ext_pin2_irq_flag, ext_pin1_irq_flag, ext_pin0_irq_flag};

  fit_matcher u_match (
    .flags(flags_live),
    .arm(arm_r),
    .hit(hit)
  );

  assign timer_nxt = timer_cfg ? `FIT_WORD_ZERO : (major_tick ? timer_r + 16'h0001 : timer_r);
  // overflow set wins over a software clear in the same cycle
  assign toflag_nxt = word_wrap ? 1'b1 : ((timer_cfg || toflag_clr) ? 1'b0 : toflag_r);

  wire take = (st_r == fit_pkg::FIT_ST_ARMED) && poll_point && hit;

  always_comb
  begin
    st_nxt = st_r;
    arm_nxt = arm_r;
    pend_nxt = pend_r;
    pend_valid_nxt = pend_valid_r;
    case (st_r)
      fit_pkg::FIT_ST_IDLE:
      begin
        if (int_arm)
        begin
          arm_nxt = int_arm_val;
          st_nxt = fit_pkg::FIT_ST_ARMED;
        end
      end
      fit_pkg::FIT_ST_ARMED:
      begin
        if (int_off)
          st_nxt = fit_pkg::FIT_ST_IDLE;
        else if (int_arm)
          arm_nxt = int_arm_val;
        else if (take)
        begin
          st_nxt = fit_pkg::FIT_ST_HANDLER;
          pend_valid_nxt = 1'b0;
        end
      end
      fit_pkg::FIT_ST_HANDLER:
      begin
        if (int_arm)
        begin
          pend_nxt = int_arm_val;
          pend_valid_nxt = 1'b1;
        end
        else if (int_off)
          pend_valid_nxt = 1'b0;
        if (handler_return)
        begin
          if (int_arm || (pend_valid_r && !int_off))
          begin
            arm_nxt = int_arm ? int_arm_val : pend_r;
            st_nxt = fit_pkg::FIT_ST_ARMED;
          end
          else
            st_nxt = fit_pkg::FIT_ST_IDLE;
          pend_valid_nxt = 1'b0;
        end
      end
      default:
        st_nxt = fit_pkg::FIT_ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= fit_pkg::FIT_ST_IDLE;
      arm_r <= '0;
      pend_r <= '0;
      pend_valid_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      arm_r <= arm_nxt;
      pend_r <= pend_nxt;
      pend_valid_r <= pend_valid_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      run_r <= 1'b0;
      count_mode_r <= 1'b0;
      preload_r <= `FIT_WORD_ZERO;
    end
    else if (timer_cfg)
    begin
      run_r <= 1'b1;
      count_mode_r <= timer_cfg_val.count_mode;
      preload_r <= timer_cfg_val.preload;
    end
    else if (timer_off)
      run_r <= 1'b0;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_r <= `FIT_BYTE_ZERO;
      in0_d_r <= 1'b0;
      timer_r <= `FIT_WORD_ZERO;
      toflag_r <= 1'b0;
    end
    else
    begin
      // prescaler restarts on configure so the first minor tick is a full period
      div_r <= timer_cfg ? `FIT_BYTE_ZERO : (active ? div_r + 8'h01 : div_r);
      in0_d_r <= count_in0;
      timer_r <= timer_nxt;
      toflag_r <= toflag_nxt;
    end
  end

  // registered outputs
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      timer_word <= `FIT_WORD_ZERO;
      flags_byte <= `FIT_BYTE_ZERO;
      timer_running <= 1'b0;
      timer_blocked <= 1'b0;
      int_armed <= 1'b0;
      int_call <= 1'b0;
      in_handler <= 1'b0;
    end
    else
    begin
      timer_word <= timer_nxt;
      flags_byte <= flags_live;
      timer_running <= active;
      timer_blocked <= blocked;
      int_armed <= (st_nxt == fit_pkg::FIT_ST_ARMED);
      int_call <= take && !int_off && !int_arm;
      in_handler <= (st_nxt == fit_pkg::FIT_ST_HANDLER);
    end
  end
endmodule : fit_core

// >>> common/fit_params.svh
// constants for the flag interrupt timer
`ifndef FIT_PARAMS_SVH
`define FIT_PARAMS_SVH
`define FIT_MINOR_DIV 9'h100
`define FIT_MINOR_LAST 8'hFF
`define FIT_TOFLAG_BIT 7
`define FIT_SLAVE_WR_BIT 6
`define FIT_SER_RX_BIT 5
`define FIT_COMP_BIT 4
`define FIT_ANY_PIN_BIT 3
`define FIT_WORD_MAX 16'hFFFF
`define FIT_WORD_ZERO 16'h0000
`define FIT_BYTE_ZERO 8'h00
`endif

// >>> common/fit_pkg.sv
// types for the flag interrupt timer
package fit_pkg;
  typedef enum logic [1:0] {
    FIT_MODE_AND = 2'b00,
    FIT_MODE_OR = 2'b01,
    FIT_MODE_NOT = 2'b10
  } fit_mode_t;
  typedef enum logic [1:0] {
    FIT_ST_IDLE = 2'b00,
    FIT_ST_ARMED = 2'b01,
    FIT_ST_HANDLER = 2'b10
  } fit_state_t;
  typedef struct packed {
    logic [7:0] pattern;
    logic [7:0] mask;
    fit_mode_t mode;
  } fit_arm_t;
  typedef struct packed {
    logic count_mode;
    logic [15:0] preload;
  } fit_cfg_t;
endpackage : fit_pkg

// >>> src/fit_tick_counter.sv
// hidden 16-bit tick or edge counter with preload reload
`timescale 1ns/100ps
`include "fit_params.svh"
module fit_tick_counter (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // control
  input wire logic load,
  input wire logic [15:0] preload,
  input wire logic step,
  // result
  output logic wrap
);
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  wire at_max = (cnt_r == `FIT_WORD_MAX);
  assign wrap = step && at_max;
  // reload on wrap so only the remainder up to 65536 elapses
  assign cnt_nxt = load ? preload : (wrap ? preload : (step ? cnt_r + 16'h0001 : cnt_r));
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_r <= `FIT_WORD_ZERO;
    else
      cnt_r <= cnt_nxt;
  end
endmodule : fit_tick_counter

// >>> src/fit_matcher.sv
// flags byte pattern matcher
`timescale 1ns/100ps
module fit_matcher (
  // inputs
  input wire logic [7:0] flags,
  input wire fit_pkg::fit_arm_t arm,
  // result
  output logic hit
);
  wire [7:0] masked = flags & arm.mask;
  wire [7:0] agree = ~(masked ^ arm.pattern) & arm.mask;
  wire and_hit = (masked == (arm.pattern & arm.mask));
  wire or_hit = |agree;
  assign hit = (arm.mode == fit_pkg::FIT_MODE_OR) ? or_hit :
               (arm.mode == fit_pkg::FIT_MODE_NOT) ? !and_hit : and_hit;
endmodule : fit_matcher

// >>> test/fit_core_props.sv
// port assertions for the flag interrupt timer
`timescale 1ns/100ps
module fit_core_props (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // inputs
  input wire logic timer_cfg,
  input wire logic timer_off,
  input wire logic debug_dump_busy,
  input wire logic servo_active,
  input wire logic slave_write_done_flag,
  input wire logic ser_rx_done_flag,
  input wire logic comp_out_flag,
  input wire logic ext_pin0_irq_flag,
  input wire logic ext_pin1_irq_flag,
  input wire logic ext_pin2_irq_flag,
  input wire logic poll_point,
  // outputs
  input wire logic [15:0] timer_word,
  input wire logic [7:0] flags_byte,
  input wire logic timer_running,
  input wire logic int_armed,
  input wire logic int_call,
  input wire logic in_handler
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire [2:0] pins = {ext_pin2_irq_flag, ext_pin1_irq_flag, ext_pin0_irq_flag};
  // pipeline to the word is one register deep; the hold spans three cycles
  sequence s_hold; ((debug_dump_busy || servo_active) && !timer_cfg) [*3]; endsequence
  sequence s_poll; $past(int_armed) && $past(poll_point); endsequence
  property p_pins; flags_byte[3:0] == {|$past(pins), $past(pins)}; endproperty
  a_pins: assert property (p_pins) else $error("pin flag bits wrong");
  property p_src; flags_byte[6:4] == $past({slave_write_done_flag, ser_rx_done_flag, comp_out_flag}); endproperty
  a_src: assert property (p_src) else $error("source flag bits wrong");
  property p_call; int_call |-> s_poll; endproperty
  a_call: assert property (p_call) else $error("call without armed poll");
  property p_pulse; int_call |=> !int_call; endproperty
  a_pulse: assert property (p_pulse) else $error("call longer than one cycle");
  property p_disarm; int_call |-> !int_armed && in_handler; endproperty
  a_disarm: assert property (p_disarm) else $error("still armed after call");
  property p_cfg; timer_cfg |=> timer_word == 16'h0000; endproperty
  a_cfg: assert property (p_cfg) else $error("word not cleared on configure");
  // running status is one register behind the run bit
  property p_off; timer_off && !timer_cfg |-> ##2 !timer_running; endproperty
  a_off: assert property (p_off) else $error("timer runs after off");
  property p_stall; s_hold |=> $stable(timer_word); endproperty
  a_stall: assert property (p_stall) else $error("word moved while suspended");
  property p_step; timer_word != $past(timer_word) |-> timer_word == $past(timer_word) + 16'h0001
    || timer_word == 16'h0000; endproperty
  a_step: assert property (p_step) else $error("word stepped by more than one");
  property p_toclr; timer_cfg |=> ##1 !flags_byte[7]; endproperty
  a_toclr: assert property (p_toclr) else $error("overflow flag kept after configure");
endmodule : fit_core_props

// >>> test/fit_core_bench.sv
// self-checking bench for the flag interrupt timer
`timescale 1ns/100ps
module fit_core_bench;
  logic core_clk, rst_n, timer_cfg, timer_off, toflag_clr, debug_dump_busy, servo_active, count_in0;
  logic slave_write_done_flag, ser_rx_done_flag, comp_out_flag;
  logic ext_pin0_irq_flag, ext_pin1_irq_flag, ext_pin2_irq_flag;
  logic int_arm, int_off, poll_point, handler_return;
  logic timer_running, timer_blocked, int_armed, int_call, in_handler;
  logic [15:0] timer_word;
  logic [7:0] flags_byte, src, ef;
  fit_pkg::fit_cfg_t timer_cfg_val;
  fit_pkg::fit_arm_t int_arm_val, a;
  integer n_fail = 0, checked = 0, seed = 12, i;
  assign {slave_write_done_flag, ser_rx_done_flag, comp_out_flag} = src[6:4];
  assign {ext_pin2_irq_flag, ext_pin1_irq_flag, ext_pin0_irq_flag} = src[2:0];
  fit_core uut (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .timer_cfg(timer_cfg),
    .timer_cfg_val(timer_cfg_val),
    .timer_off(timer_off),
    .toflag_clr(toflag_clr),
    .debug_dump_busy(debug_dump_busy),
    .servo_active(servo_active),
    .count_in0(count_in0),
    .slave_write_done_flag(slave_write_done_flag),
    .ser_rx_done_flag(ser_rx_done_flag),
    .comp_out_flag(comp_out_flag),
    .ext_pin0_irq_flag(ext_pin0_irq_flag),
    .ext_pin1_irq_flag(ext_pin1_irq_flag),
    .ext_pin2_irq_flag(ext_pin2_irq_flag),
    .int_arm(int_arm),
    .int_arm_val(int_arm_val),
    .int_off(int_off),
    .poll_point(poll_point),
    .handler_return(handler_return),
    .timer_word(timer_word),
    .flags_byte(flags_byte),
    .timer_running(timer_running),
    .timer_blocked(timer_blocked),
    .int_armed(int_armed),
    .int_call(int_call),
    .in_handler(in_handler)
  );
  function automatic logic hit(input logic [7:0] f, input fit_pkg::fit_arm_t v);
    logic [7:0] x;
    x = ~(f ^ v.pattern) & v.mask;
    if (v.mode == fit_pkg::FIT_MODE_OR)
      return |x;
    if (v.mode == fit_pkg::FIT_MODE_NOT)
      return x != v.mask;
    return x == v.mask;
  endfunction : hit
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input integer n);
    repeat (n) @(negedge core_clk);
  endtask : cyc
  task automatic edges(input integer n);
    repeat (n)
    begin
      count_in0 = 1;
      cyc(1);
      count_in0 = 0;
      cyc(1);
    end
    cyc(2);
  endtask : edges
  task automatic cfg(input fit_pkg::fit_cfg_t v);
    timer_cfg_val = v;
    timer_cfg = 1;
    cyc(1);
    timer_cfg = 0;
    chk(timer_word, 16'h0000);
  endtask : cfg
  task automatic print_verdict;
    $display("counts: %0d checked, %0d mismatched", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  initial
  begin
    core_clk = 0;
    forever #5 core_clk = ~core_clk;
  end
  initial
  begin
    #100000;
    n_fail++;
    print_verdict;
  end
  initial
  begin
    {rst_n, timer_cfg, timer_off, toflag_clr, debug_dump_busy, servo_active, count_in0} = '0;
    {int_arm, int_off, poll_point, handler_return, timer_cfg_val, int_arm_val, src} = '0;
    cyc(10);
    rst_n = 1;
    for (i = 0; i < 30; i++)
    begin
      src = 8'($random(seed));
      {a.pattern, a.mask} = 16'($random(seed));
      a.mode = fit_pkg::fit_mode_t'(i % 3);
      if (i < 3)
        a.mask = 8'h00;
      ef = {1'b0, src[6:4], |src[2:0], src[2:0]};
      cyc(2);
      chk(flags_byte, ef);
      // empty-mask AND first, so a lost replace shows as a call
      int_arm_val = '0;
      int_arm = 1;
      cyc(1);
      int_arm_val = a;
      cyc(1);
      int_arm = 0;
      poll_point = 1;
      cyc(1);
      chk(int_call, hit(ef, a));
      poll_point = 0;
      if (hit(ef, a))
      begin
        int_arm = 1;
        poll_point = 1;
        cyc(1);
        int_arm = 0;
        handler_return = 1;
        cyc(1);
        handler_return = 0;
        chk(int_call, 0);
        cyc(1);
        chk(int_call, 1);
        poll_point = 0;
      end
      handler_return = 1;
      cyc(1);
      handler_return = 0;
      int_off = 1;
      cyc(1);
      int_off = 0;
      chk({int_armed, in_handler}, 0);
    end
    $display("test matcher done");
    cfg({1'b1, 16'hFFFF});
    edges(5);
    chk(timer_word, 5);
    cfg({1'b1, 16'hFFFD});
    edges(7);
    chk(timer_word, 2);
    debug_dump_busy = 1;
    edges(4);
    debug_dump_busy = 0;
    servo_active = 1;
    cyc(1);
    chk(timer_blocked, 1);
    edges(4);
    servo_active = 0;
    chk(timer_word, 2);
    edges(2);
    chk({timer_blocked, timer_word}, 3);
    timer_off = 1;
    cyc(1);
    timer_off = 0;
    edges(6);
    chk({timer_running, timer_word}, 3);
    $display("test counter done");
    cfg({1'b0, 16'hFFFE});
    toflag_clr = 1;
    cyc(1030);
    toflag_clr = 0;
    chk({timer_running, timer_word}, 17'h10002);
    chk(flags_byte[7], 0);
    $display("test internal timer done");
    print_verdict;
  end
endmodule : fit_core_bench
bind fit_core fit_core_props u_props (
  .core_clk(core_clk),
  .rst_n(rst_n),
  .timer_cfg(timer_cfg),
  .timer_off(timer_off),
  .debug_dump_busy(debug_dump_busy),
  .servo_active(servo_active),
  .slave_write_done_flag(slave_write_done_flag),
  .ser_rx_done_flag(ser_rx_done_flag),
  .comp_out_flag(comp_out_flag),
  .ext_pin0_irq_flag(ext_pin0_irq_flag),
  .ext_pin1_irq_flag(ext_pin1_irq_flag),
  .ext_pin2_irq_flag(ext_pin2_irq_flag),
  .poll_point(poll_point),
  .timer_word(timer_word),
  .flags_byte(flags_byte),
  .timer_running(timer_running),
  .int_armed(int_armed),
  .int_call(int_call),
  .in_handler(in_handler)
);
